// ==== verilog/afpm_pkg.sv ====
// Package for the amplifier fault protection monitor: register map, fields, timing
package afpm_pkg;
    // --------------------------------------------------------------
    // Register offsets
    // --------------------------------------------------------------
    localparam logic [7:0] ADDR_DC_SHUTDOWN_CTRL = 8'h26;
    localparam logic [7:0] ADDR_ERROR_CLEAR_CTRL = 8'h2d;
    localparam logic [7:0] ADDR_FAULT_STATUS = 8'h7c;
    // --------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------
    localparam int BIT_DC_PROT_EN = 2;
    localparam int BIT_ERROR_HOLD_CLEAR = 2;
    localparam int BIT_OVERCURRENT = 0;
    localparam int BIT_DC_DETECT = 1;
    localparam int BIT_UNDERVOLTAGE = 2;
    localparam int BIT_THERMAL_WARNING = 4;
    localparam int BIT_THERMAL_ERROR = 5;
    // --------------------------------------------------------------
    // Reset values
    // --------------------------------------------------------------
    localparam logic [7:0] RST_DC_SHUTDOWN_CTRL = 8'h04;
    localparam logic [7:0] RST_ERROR_CLEAR_CTRL = 8'h00;
    // --------------------------------------------------------------
    // Thresholds, in degrees C and millivolts
    // --------------------------------------------------------------
    localparam logic [7:0] TE_SET_DEGC = 8'd150;
    localparam logic [7:0] TE_CLR_DEGC = 8'd135;
    localparam logic [7:0] TW_SET_DEGC = 8'd125;
    localparam logic [7:0] TW_CLR_DEGC = 8'd105;
    localparam logic [12:0] UV_LOGIC_RISE_MV = 13'd4200;
    localparam logic [12:0] UV_LOGIC_FALL_MV = 13'd4000;
    localparam logic [12:0] UV_POWER_RISE_MV = 13'd4300;
    localparam logic [12:0] UV_POWER_FALL_MV = 13'd4100;
    // DC window as fractions of 1000 of the power-stage supply
    localparam logic [9:0] DC_HIGH_PERMILLE = 10'd630;
    localparam logic [9:0] DC_LOW_PERMILLE = 10'd370;
    // --------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------
    localparam longint CLK_PERIOD_PS = 10000;
    localparam longint DC_TRIP_MS = 700;
    localparam longint DC_TRIP_CYCLES = (DC_TRIP_MS * 64'd1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam longint RESTART_US = 10;
    localparam longint RESTART_CYCLES = (RESTART_US * 64'd1000000) / CLK_PERIOD_PS;
    // --------------------------------------------------------------
    // Carriers
    // --------------------------------------------------------------
    typedef struct packed {
        logic [12:0] power_stage_supply;
        logic [12:0] digital_supply;
        logic [12:0] analog_supply;
    } afpm_supply_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } afpm_reg_req_t;
    typedef enum logic [1:0] {
        ST_RUN,
        ST_OC_OFF,
        ST_DC_OFF
    } afpm_stage_t;
endpackage

// ==== verilog/afpm_dc_detect.sv ====
// Per-output DC detector: window compare against the supply and a persistence counter
`timescale 1ns/1ps
module afpm_dc_detect #(
    parameter int CNT_W = 27,
    parameter longint TRIP_CYCLES = afpm_pkg::DC_TRIP_CYCLES
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // Levels, in millivolts, and the clear of count and trip
    input wire logic [12:0] i_level_mv,
    input wire logic [12:0] i_supply_mv,
    input wire logic i_clear,
    // Result
    output logic o_trip
);
    logic [22:0] level_x;
    logic [22:0] hi_lim;
    logic [22:0] lo_lim;
    logic outside;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic trip_ff;
    logic nxt_trip;

    always_comb begin
        level_x = 23'(i_level_mv) * 23'd1000;
        hi_lim = 23'(i_supply_mv) * 23'(afpm_pkg::DC_HIGH_PERMILLE);
        lo_lim = 23'(i_supply_mv) * 23'(afpm_pkg::DC_LOW_PERMILLE);
        outside = (level_x > hi_lim) || (level_x < lo_lim);
        nxt_cnt = cnt_ff;
        nxt_trip = trip_ff;
        // Any return inside the window restarts the persistence count
        if (!outside || i_clear) begin
            nxt_cnt = '0;
        end else if (cnt_ff != CNT_W'(TRIP_CYCLES)) begin
            nxt_cnt = cnt_ff + CNT_W'(1);
        end
        if (i_clear) begin
            nxt_trip = 1'b0;
        end else if (outside && cnt_ff == CNT_W'(TRIP_CYCLES)) begin
            nxt_trip = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            cnt_ff <= '0;
            trip_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            trip_ff <= nxt_trip;
        end
    end

    assign o_trip = trip_ff;

    a_dc_needs_time: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        $rose(trip_ff) |-> $past(cnt_ff) == CNT_W'(TRIP_CYCLES))
        else $error("DC trip without full persistence");
endmodule

// ==== verilog/afpm_top.sv ====
// Fault protection monitor top: thermal, supply, over-current and DC supervision
`timescale 1ns/1ps
module afpm_top #(
    parameter int N_SW = 4,
    parameter int DC_CNT_W = 27,
    parameter longint DC_TRIP = afpm_pkg::DC_TRIP_CYCLES,
    parameter longint RESTART = afpm_pkg::RESTART_CYCLES,
    parameter bit AUTO_RESTART = 1'b1
) (
    // Clock and reset (reset driven from the chip-enable pin)
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // Register access port
    input wire afpm_pkg::afpm_reg_req_t i_reg_req,
    output logic [7:0] o_reg_rdata,
    // Power stage
    input wire logic [N_SW-1:0] i_switch_on,
    input wire logic [N_SW-1:0] i_overcurrent_limit_level,
    input wire logic [N_SW-1:0][12:0] i_output_switch_node,
    output logic o_stage_enable,
    // Monitors
    input wire logic [7:0] i_temp_degc,
    input wire afpm_pkg::afpm_supply_t i_supply,
    // Fault pin
    output logic o_fault_n
);
    localparam int RC_W = 32;

    // --------------------------------------------------------------
    // Pin synchronisers (monitor inputs come from analog domain)
    // --------------------------------------------------------------
    logic [N_SW-1:0] oc_s1_ff;
    logic [N_SW-1:0] oc_s2_ff;
    logic [N_SW-1:0] on_s1_ff;
    logic [N_SW-1:0] on_s2_ff;
    logic [7:0] temp_s1_ff;
    logic [7:0] temp_s2_ff;
    afpm_pkg::afpm_supply_t sup_s1_ff;
    afpm_pkg::afpm_supply_t sup_s2_ff;
    logic [N_SW-1:0][12:0] node_s1_ff;
    logic [N_SW-1:0][12:0] node_s2_ff;

    always_ff @(posedge i_sys_clk) begin
        oc_s1_ff <= i_overcurrent_limit_level;
        oc_s2_ff <= oc_s1_ff;
        on_s1_ff <= i_switch_on;
        on_s2_ff <= on_s1_ff;
        temp_s1_ff <= i_temp_degc;
        temp_s2_ff <= temp_s1_ff;
        sup_s1_ff <= i_supply;
        sup_s2_ff <= sup_s1_ff;
        node_s1_ff <= i_output_switch_node;
        node_s2_ff <= node_s1_ff;
    end

    // --------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------
    logic [7:0] dcctl_ff;
    logic [7:0] nxt_dcctl;
    logic [7:0] clrctl_ff;
    logic [7:0] nxt_clrctl;
    logic clear_pulse;

    always_comb begin
        nxt_dcctl = dcctl_ff;
        nxt_clrctl = clrctl_ff;
        if (i_reg_req.wr && i_reg_req.addr == afpm_pkg::ADDR_DC_SHUTDOWN_CTRL) begin
            nxt_dcctl = i_reg_req.wdata;
        end
        if (i_reg_req.wr && i_reg_req.addr == afpm_pkg::ADDR_ERROR_CLEAR_CTRL) begin
            nxt_clrctl = i_reg_req.wdata;
        end
    end

    // A toggle of the clear bit in either direction counts as a clear request
    assign clear_pulse = nxt_clrctl[afpm_pkg::BIT_ERROR_HOLD_CLEAR]
        != clrctl_ff[afpm_pkg::BIT_ERROR_HOLD_CLEAR];

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            dcctl_ff <= afpm_pkg::RST_DC_SHUTDOWN_CTRL;
            clrctl_ff <= afpm_pkg::RST_ERROR_CLEAR_CTRL;
        end else begin
            dcctl_ff <= nxt_dcctl;
            clrctl_ff <= nxt_clrctl;
        end
    end

    // --------------------------------------------------------------
    // Thermal and supply hysteresis
    // --------------------------------------------------------------
    logic tw_ff;
    logic nxt_tw;
    logic te_ff;
    logic nxt_te;
    logic [2:0] uv_ff;
    logic [2:0] nxt_uv;
    logic [2:0][12:0] rail;
    logic [2:0][12:0] rise_mv;
    logic [2:0][12:0] fall_mv;

    assign rail = {sup_s2_ff.power_stage_supply, sup_s2_ff.digital_supply, sup_s2_ff.analog_supply};
    assign rise_mv = {afpm_pkg::UV_POWER_RISE_MV, afpm_pkg::UV_LOGIC_RISE_MV, afpm_pkg::UV_LOGIC_RISE_MV};
    assign fall_mv = {afpm_pkg::UV_POWER_FALL_MV, afpm_pkg::UV_LOGIC_FALL_MV, afpm_pkg::UV_LOGIC_FALL_MV};

    always_comb begin
        nxt_tw = tw_ff;
        nxt_te = te_ff;
        if (temp_s2_ff >= afpm_pkg::TW_SET_DEGC) begin
            nxt_tw = 1'b1;
        end else if (temp_s2_ff <= afpm_pkg::TW_CLR_DEGC) begin
            nxt_tw = 1'b0;
        end
        if (temp_s2_ff >= afpm_pkg::TE_SET_DEGC) begin
            nxt_te = 1'b1;
        end else if (temp_s2_ff <= afpm_pkg::TE_CLR_DEGC) begin
            nxt_te = 1'b0;
        end
    end

    // One lockout flag per rail; below fall trips, at or above rise releases
    for (genvar r = 0; r < 3; r++) begin : g_uv
        always_comb begin
            nxt_uv[r] = uv_ff[r];
            if (rail[r] < fall_mv[r]) begin
                nxt_uv[r] = 1'b1;
            end else if (rail[r] >= rise_mv[r]) begin
                nxt_uv[r] = 1'b0;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            tw_ff <= 1'b0;
            te_ff <= 1'b0;
            // Rails count as low until seen at or above the release level
            uv_ff <= 3'h7;
        end else begin
            tw_ff <= nxt_tw;
            te_ff <= nxt_te;
            uv_ff <= nxt_uv;
        end
    end

    // --------------------------------------------------------------
    // DC detection
    // --------------------------------------------------------------
    logic [N_SW-1:0] dc_trip;
    logic dc_en;
    logic dc_latch_ff;

    assign dc_en = dcctl_ff[afpm_pkg::BIT_DC_PROT_EN];

    for (genvar s = 0; s < N_SW; s++) begin : g_dc
        afpm_dc_detect #(
            .CNT_W(DC_CNT_W),
            .TRIP_CYCLES(DC_TRIP)
        ) u_dc (
            .i_sys_clk(i_sys_clk),
            .i_rst_n(i_rst_n),
            .i_level_mv(node_s2_ff[s]),
            .i_supply_mv(sup_s2_ff.power_stage_supply),
            .i_clear(!dc_en || clear_pulse || !o_stage_enable && !dc_latch_ff),
            .o_trip(dc_trip[s])
        );
    end

    // --------------------------------------------------------------
    // Power stage state and latched errors
    // --------------------------------------------------------------
    afpm_pkg::afpm_stage_t st_ff;
    afpm_pkg::afpm_stage_t nxt_st;
    logic [RC_W-1:0] rc_ff;
    logic [RC_W-1:0] nxt_rc;
    logic oc_latch_ff;
    logic nxt_oc_latch;
    logic nxt_dc_latch;
    logic [7:0] hold_ff;
    logic [7:0] nxt_hold;
    logic oc_now;
    logic dc_now;
    logic [7:0] live;

    // Only a conducting switch can report a real over-current
    assign oc_now = |(oc_s2_ff & on_s2_ff) && st_ff == afpm_pkg::ST_RUN;
    assign dc_now = |dc_trip && dc_en && !dc_latch_ff;

    always_comb begin
        live = 8'h00;
        live[afpm_pkg::BIT_THERMAL_WARNING] = tw_ff;
        live[afpm_pkg::BIT_THERMAL_ERROR] = te_ff;
        live[afpm_pkg::BIT_UNDERVOLTAGE] = |uv_ff;
        live[afpm_pkg::BIT_OVERCURRENT] = oc_now;
        live[afpm_pkg::BIT_DC_DETECT] = dc_now;
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_rc = rc_ff;
        nxt_oc_latch = oc_latch_ff;
        nxt_dc_latch = dc_latch_ff;
        // New events win over a simultaneous clear
        nxt_hold = (clear_pulse ? 8'h00 : hold_ff) | live;
        if (clear_pulse) begin
            nxt_oc_latch = 1'b0;
            nxt_dc_latch = 1'b0;
        end
        unique case (st_ff)
            afpm_pkg::ST_RUN: begin
                if (dc_now) begin
                    nxt_st = afpm_pkg::ST_DC_OFF;
                    nxt_dc_latch = 1'b1;
                end else if (oc_now) begin
                    nxt_st = afpm_pkg::ST_OC_OFF;
                    nxt_oc_latch = 1'b1;
                    nxt_rc = '0;
                end
            end
            afpm_pkg::ST_OC_OFF: begin
                // Waits for the restart delay or a software clear
                if (rc_ff != RC_W'(RESTART)) begin
                    nxt_rc = rc_ff + RC_W'(1);
                end
                if ((AUTO_RESTART && rc_ff == RC_W'(RESTART)) || clear_pulse) begin
                    nxt_st = afpm_pkg::ST_RUN;
                end
            end
            afpm_pkg::ST_DC_OFF: begin
                if (clear_pulse) begin
                    nxt_st = afpm_pkg::ST_RUN;
                end
            end
            default: nxt_st = afpm_pkg::ST_RUN;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            st_ff <= afpm_pkg::ST_RUN;
            rc_ff <= '0;
            oc_latch_ff <= 1'b0;
            dc_latch_ff <= 1'b0;
            hold_ff <= 8'h00;
        end else begin
            st_ff <= nxt_st;
            rc_ff <= nxt_rc;
            oc_latch_ff <= nxt_oc_latch;
            dc_latch_ff <= nxt_dc_latch;
            hold_ff <= nxt_hold;
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    logic stage_en_ff;
    logic fault_n_ff;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;

    always_comb begin
        nxt_rdata = 8'h00;
        if (i_reg_req.rd) begin
            unique case (i_reg_req.addr)
                afpm_pkg::ADDR_DC_SHUTDOWN_CTRL: nxt_rdata = dcctl_ff;
                afpm_pkg::ADDR_ERROR_CLEAR_CTRL: nxt_rdata = clrctl_ff;
                afpm_pkg::ADDR_FAULT_STATUS: nxt_rdata = hold_ff;
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            stage_en_ff <= 1'b0;
            fault_n_ff <= 1'b1;
            rdata_ff <= 8'h00;
        end else begin
            // Stage stops on thermal error, lockout or any shutdown state
            stage_en_ff <= nxt_st == afpm_pkg::ST_RUN && !nxt_te && !(|nxt_uv);
            // Pin held while any fault lives or any held flag remains
            fault_n_ff <= !(tw_ff || te_ff || (|nxt_hold) || oc_latch_ff || dc_latch_ff);
            rdata_ff <= nxt_rdata;
        end
    end

    assign o_stage_enable = stage_en_ff;
    assign o_fault_n = fault_n_ff;
    assign o_reg_rdata = rdata_ff;

    a_te_stops_stage: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        te_ff |-> !o_stage_enable)
        else $error("Stage runs during thermal error");
    a_warn_drives_pin: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (tw_ff || te_ff) |=> !o_fault_n)
        else $error("Thermal fault not on pin");
    a_oc_shuts_stage: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        oc_now && !dc_now |=> st_ff == afpm_pkg::ST_OC_OFF ##0 oc_latch_ff ##1 !o_fault_n)
        else $error("Over-current not latched");
    a_dc_shuts_stage: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        dc_now && st_ff == afpm_pkg::ST_RUN |=> !o_stage_enable ##1 !o_fault_n)
        else $error("DC did not stop stage");
    a_dc_holds_off: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        st_ff == afpm_pkg::ST_DC_OFF && !clear_pulse |=> st_ff == afpm_pkg::ST_DC_OFF)
        else $error("DC shutdown left without clear");
    a_te_hyst: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        te_ff && temp_s2_ff > afpm_pkg::TE_CLR_DEGC |=> te_ff)
        else $error("Thermal error cleared above clear level");
    a_tw_hyst: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        !tw_ff && temp_s2_ff < afpm_pkg::TW_SET_DEGC |=> !tw_ff)
        else $error("Warning set below set level");
    a_status_warn: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        tw_ff |=> hold_ff[afpm_pkg::BIT_THERMAL_WARNING])
        else $error("Warning not held in status");
    a_pin_release: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        $rose(o_fault_n) |-> $past(hold_ff) == 8'h00 || $past(clear_pulse))
        else $error("Fault pin released with flags held");
endmodule

// ==== tb/afpm_far_side.sv ====
// Far-side model: power stage switches, current comparators, sensors and output nodes
`timescale 1ns/1ps
module afpm_far_side #(
    parameter int N_SW = 4
) (
    // Commands from the bench
    input wire logic [N_SW-1:0] i_sw_pattern,
    input wire logic [N_SW-1:0] i_overload,
    input wire logic [7:0] i_temp_set,
    input wire afpm_pkg::afpm_supply_t i_supply_set,
    input wire logic [12:0] i_dc_level,
    // Device side
    input wire logic i_stage_enable,
    output logic [N_SW-1:0] o_switch_on,
    output logic [N_SW-1:0] o_overcurrent_limit_level,
    output logic [N_SW-1:0][12:0] o_output_switch_node,
    output logic [7:0] o_temp_degc,
    output afpm_pkg::afpm_supply_t o_supply
);
    // A switch conducts only while the stage is allowed to switch
    assign o_switch_on = i_stage_enable ? i_sw_pattern : '0;
    // Comparator flags pass straight through, so a noisy flag on an idle switch reaches the device
    assign o_overcurrent_limit_level = i_overload;
    assign o_temp_degc = i_temp_set;
    assign o_supply = i_supply_set;
    // Level 0 means a healthy output resting at half the stage supply
    always_comb begin
        for (int k = 0; k < N_SW; k++) begin
            o_output_switch_node[k] = i_supply_set.power_stage_supply >> 1;
        end
        if (i_dc_level != 13'h0000) begin
            o_output_switch_node[0] = i_dc_level;
        end
    end
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the fault protection monitor
`timescale 1ns/1ps
module testbench;
    // ----------------------------------------------------------
    // Setup
    // ----------------------------------------------------------
    localparam int N_SW = 4;
    localparam longint DC_TRIP = 20;
    localparam longint RESTART = 5;
    localparam int TIMEOUT_CYCLES = 5000;
    localparam logic [7:0] S_OC = 8'h01 << afpm_pkg::BIT_OVERCURRENT;
    localparam logic [7:0] S_DC = 8'h01 << afpm_pkg::BIT_DC_DETECT;
    localparam logic [7:0] S_UV = 8'h01 << afpm_pkg::BIT_UNDERVOLTAGE;
    localparam logic [7:0] S_TW = 8'h01 << afpm_pkg::BIT_THERMAL_WARNING;
    localparam logic [7:0] S_TE = 8'h01 << afpm_pkg::BIT_THERMAL_ERROR;
    logic i_sys_clk = 1'b0;
    logic i_rst_n = 1'b0;
    afpm_pkg::afpm_reg_req_t i_reg_req = '0;
    logic [7:0] o_reg_rdata;
    logic o_stage_enable;
    logic o_fault_n;
    logic [N_SW-1:0] sw_on;
    logic [N_SW-1:0] oc_lvl;
    logic [N_SW-1:0][12:0] nodes;
    logic [7:0] temp;
    afpm_pkg::afpm_supply_t supply;
    logic [N_SW-1:0] sw_pattern = 4'hf;
    logic [N_SW-1:0] overload = 4'h0;
    logic [7:0] temp_set = 8'h19;
    afpm_pkg::afpm_supply_t supply_set = {13'd8000, 13'd5000, 13'd5000};
    logic [12:0] dc_level = 13'h0000;
    logic clr_bit = 1'b0;
    logic [7:0] rd;
    int error_cnt = 0;
    int comparisons = 0;
    int cycle_cnt = 0;
    int n;

    afpm_top #(.N_SW(N_SW), .DC_TRIP(DC_TRIP), .RESTART(RESTART)) dut (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_reg_req(i_reg_req), .o_reg_rdata(o_reg_rdata),
        .i_switch_on(sw_on), .i_overcurrent_limit_level(oc_lvl), .i_output_switch_node(nodes),
        .o_stage_enable(o_stage_enable), .i_temp_degc(temp), .i_supply(supply), .o_fault_n(o_fault_n));

    afpm_far_side #(.N_SW(N_SW)) far (
        .i_sw_pattern(sw_pattern), .i_overload(overload), .i_temp_set(temp_set), .i_supply_set(supply_set),
        .i_dc_level(dc_level), .i_stage_enable(o_stage_enable), .o_switch_on(sw_on),
        .o_overcurrent_limit_level(oc_lvl), .o_output_switch_node(nodes), .o_temp_degc(temp), .o_supply(supply));

    initial begin
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    // ----------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------
    task automatic end_sim();
        $display("mismatches %0d, comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // Every task that waits ends one nanosecond after a rising edge
    task automatic tick(input int cyc);
        repeat (cyc) @(posedge i_sys_clk);
        #1;
    endtask

    task automatic do_reset();
        i_rst_n = 1'b0;
        clr_bit = 1'b0;
        tick(3);
        i_rst_n = 1'b1;
        tick(8);
    endtask

    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        i_reg_req.addr = addr;
        i_reg_req.wdata = data;
        i_reg_req.wr = 1'b1;
        tick(1);
        i_reg_req.wr = 1'b0;
        tick(1);
    endtask

    // Read data stands for the one cycle after the edge that took the strobe
    task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
        i_reg_req.addr = addr;
        i_reg_req.rd = 1'b1;
        tick(1);
        i_reg_req.rd = 1'b0;
        data = o_reg_rdata;
        tick(1);
    endtask

    // Any change of the clear bit counts as one clear
    task automatic clear_errors();
        clr_bit = ~clr_bit;
        reg_write(afpm_pkg::ADDR_ERROR_CLEAR_CTRL, {5'h00, clr_bit, 2'h0});
        tick(2);
    endtask

    task automatic wait_stage(input logic exp, input int max, output int cnt);
        cnt = 0;
        while (o_stage_enable !== exp && cnt < max) begin
            tick(1);
            cnt++;
        end
    endtask

    task automatic set_temp(input logic [7:0] t);
        temp_set = t;
        tick(6);
    endtask

    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task automatic t_reset_values();
        reg_read(afpm_pkg::ADDR_DC_SHUTDOWN_CTRL, rd);
        check(rd, afpm_pkg::RST_DC_SHUTDOWN_CTRL, "dc control reset");
        reg_read(afpm_pkg::ADDR_ERROR_CLEAR_CTRL, rd);
        check(rd, afpm_pkg::RST_ERROR_CLEAR_CTRL, "clear control reset");
        reg_write(afpm_pkg::ADDR_FAULT_STATUS, 8'hff);
        reg_read(afpm_pkg::ADDR_FAULT_STATUS, rd);
        check(rd, S_UV, "status read only");
        reg_read(8'h10, rd);
        check(rd, 8'h00, "unmapped read");
        clear_errors();
        check({7'h00, o_fault_n}, 8'h01, "fault pin idle");
        check({7'h00, o_stage_enable}, 8'h01, "stage runs");
    endtask

    task automatic t_thermal();
        set_temp(8'd124);
        check({7'h00, o_fault_n}, 8'h01, "below warning");
        set_temp(8'd125);
        check({7'h00, o_fault_n}, 8'h00, "warning pin");
        check({7'h00, o_stage_enable}, 8'h01, "warning keeps running");
        reg_read(afpm_pkg::ADDR_FAULT_STATUS, rd);
        check(rd, S_TW, "warning status");
        set_temp(8'd149);
        check({7'h00, o_stage_enable}, 8'h01, "below error");
        set_temp(8'd150);
        check({7'h00, o_stage_enable}, 8'h00, "error stops");
        reg_read(afpm_pkg::ADDR_FAULT_STATUS, rd);
        check(rd, S_TW | S_TE, "error status");
        set_temp(8'd136);
        check({7'h00, o_stage_enable}, 8'h00, "error hysteresis");
        set_temp(8'd135);
        check({7'h00, o_stage_enable}, 8'h01, "error resume");
        set_temp(8'd106);
        clear_errors();
        reg_read(afpm_pkg::ADDR_FAULT_STATUS, rd);
        check(rd, S_TW, "warning hysteresis");
        set_temp(8'd105);
        check({7'h00, o_fault_n}, 8'h00, "held status keeps pin");
        clear_errors();
        check({7'h00, o_fault_n}, 8'h01, "pin released");
        set_temp(8'h19);
    endtask

    task automatic t_overcurrent();
        overload = 4'h4;
        sw_pattern = 4'hb;
        tick(10);
        check({7'h00, o_stage_enable}, 8'h01, "flag on idle switch");
        check({7'h00, o_fault_n}, 8'h01, "no fault from idle switch");
        sw_pattern = 4'h4;
        wait_stage(1'b0, 10, n);
        check({7'h00, o_stage_enable}, 8'h00, "over-current stops");
        check({7'h00, o_fault_n}, 8'h00, "over-current pin");
        overload = 4'h0;
        wait_stage(1'b1, RESTART + 10, n);
        check({7'h00, o_stage_enable}, 8'h01, "automatic restart");
        reg_read(afpm_pkg::ADDR_FAULT_STATUS, rd);
        check(rd, S_OC, "over-current status");
        check({7'h00, o_fault_n}, 8'h00, "pin held after restart");
        clear_errors();
        check({7'h00, o_fault_n}, 8'h01, "pin released");
        sw_pattern = 4'hf;
    endtask

    task automatic uv_rail(input int r, input logic [12:0] mv, input logic exp);
        case (r)
            0: supply_set.digital_supply = mv;
            1: supply_set.analog_supply = mv;
            default: supply_set.power_stage_supply = mv;
        endcase
        tick(6);
        check({7'h00, o_stage_enable}, {7'h00, exp}, "supply lockout");
    endtask

    task automatic t_undervoltage();
        logic [12:0] fall [3];
        logic [12:0] rise [3];
        fall = '{afpm_pkg::UV_LOGIC_FALL_MV, afpm_pkg::UV_LOGIC_FALL_MV, afpm_pkg::UV_POWER_FALL_MV};
        rise = '{afpm_pkg::UV_LOGIC_RISE_MV, afpm_pkg::UV_LOGIC_RISE_MV, afpm_pkg::UV_POWER_RISE_MV};
        for (int r = 0; r < 3; r++) begin
            uv_rail(r, fall[r], 1'b1);
            uv_rail(r, fall[r] - 13'd1, 1'b0);
            uv_rail(r, rise[r] - 13'd1, 1'b0);
            uv_rail(r, rise[r], 1'b1);
        end
        reg_read(afpm_pkg::ADDR_FAULT_STATUS, rd);
        check(rd, S_UV, "lockout status");
        supply_set = {13'd8000, 13'd5000, 13'd5000};
        clear_errors();
        tick(6);
    endtask

    task automatic t_dc();
        dc_level = 13'd5040;
        tick(40);
        check({7'h00, o_stage_enable}, 8'h01, "upper edge of window");
        dc_level = 13'd2960;
        tick(40);
        check({7'h00, o_stage_enable}, 8'h01, "lower edge of window");
        dc_level = 13'd5041;
        tick(15);
        dc_level = 13'h0000;
        tick(40);
        check({7'h00, o_stage_enable}, 8'h01, "short excursion");
        dc_level = 13'd5041;
        wait_stage(1'b0, 60, n);
        check({7'h00, o_stage_enable}, 8'h00, "dc stops stage");
        check({7'h00, n >= DC_TRIP}, 8'h01, "dc persistence");
        check({7'h00, o_fault_n}, 8'h00, "dc pin");
        reg_read(afpm_pkg::ADDR_FAULT_STATUS, rd);
        check(rd, S_DC, "dc status");
        dc_level = 13'h0000;
        tick(20);
        check({7'h00, o_stage_enable}, 8'h00, "dc shutdown latched");
        clear_errors();
        check({7'h00, o_stage_enable}, 8'h01, "clear restarts");
        check({7'h00, o_fault_n}, 8'h01, "clear releases pin");
        dc_level = 13'd2959;
        wait_stage(1'b0, 60, n);
        check({7'h00, o_stage_enable}, 8'h00, "low dc stops stage");
        dc_level = 13'h0000;
        do_reset();
        check({7'h00, o_stage_enable}, 8'h01, "enable cycle restarts");
        reg_write(afpm_pkg::ADDR_DC_SHUTDOWN_CTRL, 8'h00);
        reg_read(afpm_pkg::ADDR_DC_SHUTDOWN_CTRL, rd);
        check(rd, 8'h00, "dc control write");
        dc_level = 13'd5041;
        tick(60);
        check({7'h00, o_stage_enable}, 8'h01, "dc protection off");
        dc_level = 13'h0000;
    endtask

    // ----------------------------------------------------------
    // Main sequence and hang guard
    // ----------------------------------------------------------
    always @(posedge i_sys_clk) begin
        cycle_cnt++;
        if (cycle_cnt >= TIMEOUT_CYCLES) begin
            error_cnt++;
            $display("wrong value at %0t: run exceeded its cycle budget", $time);
            end_sim();
        end
    end

    initial begin
        do_reset();
        t_reset_values();
        t_thermal();
        t_overcurrent();
        t_undervoltage();
        t_dc();
        end_sim();
    end
endmodule
